// ### core_model.sv
// processor-core model that issues multiply-accumulate requests
`timescale 1ns/1ps
module core_model
	import mac_pkg::*;
(
	input wire logic	core_clk,
	output mac_req_t	op_req,
	output logic	op_valid
);
	initial begin
		op_valid = 1'b0;
		op_req = '1;
	end
	// outside a request the operands are inverted so stale values never pass
	task issue(input mac_req_t r);
		@(posedge core_clk);
		op_valid <= 1'b1;
		op_req <= r;
		@(posedge core_clk);
		op_valid <= 1'b0;
		op_req <= ~r;
	endtask
endmodule

// ### mac_assertions.sv
// port-level checker for the multiply-accumulate datapath
`timescale 1ns/1ps
module mac_checker
	import mac_pkg::*;
#(
	parameter int ADDR_W = 4
) (
	input wire logic	core_clk,
	input wire logic	rst,
	input wire logic [ADDR_W-1:0]	reg_addr,
	input wire logic [31:0]	reg_wdata,
	input wire logic	reg_wr,
	input wire logic	reg_rd,
	input wire logic [31:0]	reg_rdata,
	input wire logic	op_valid,
	input wire mac_req_t	op_req,
	input wire logic [31:0]	acc_value,
	input wire mac_flags_t	flags
);
	// mode bits only change on status writes, so a shadow is enough
	logic [2:0]	mode_r;
	logic [63:0]	uprod;
	wire	op_go = op_valid && !reg_wr;
	assign uprod = 64'(op_req.rx) * 64'(op_req.ry);
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst)
			mode_r <= 3'h0;
		else if (reg_wr && reg_addr == STATUS_OFFSET)
			mode_r <= reg_wdata[7:5];
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	acc_load_a: assert property (
		reg_wr && reg_addr == ACC_OFFSET |=> acc_value == $past(reg_wdata) && !flags.ovf)
		else $error("bad accumulator load");
	stat_load_a: assert property (
		reg_wr && reg_addr == STATUS_OFFSET |=> flags == {$past(reg_wdata[1]), $past(reg_wdata[3:2])})
		else $error("bad status load");
	ovf_sticky_a: assert property (
		flags.ovf && !reg_wr |=> flags.ovf)
		else $error("overflow flag dropped");
	zero_flag_a: assert property (
		op_go && !flags.ovf |=> flags.zero == (acc_value == ALL_ZEROS))
		else $error("zero flag wrong");
	neg_flag_a: assert property (
		op_go && !flags.ovf |=> flags.neg == acc_value[31])
		else $error("negative flag wrong");
	idle_hold_a: assert property (
		!op_valid && !reg_wr |=> $stable(acc_value) && $stable(flags))
		else $error("state moved while idle");
	sat_block_a: assert property (
		op_go && mode_r[2] && flags.ovf |=> $stable(acc_value) && $stable(flags))
		else $error("blocked operation changed state");
	uns_sat_a: assert property (
		op_go && mode_r == 3'h6 && !flags.ovf && !op_req.word_size && uprod[63:32] != 32'h0
		|=> flags.ovf && acc_value == ($past(op_req.subtract) ? ALL_ZEROS : ALL_ONES))
		else $error("unsigned saturation wrong");
	cover property (op_go && mode_r == 3'h6);
	cover property ($rose(flags.ovf));
	cover property (op_go && mode_r[0]);
endmodule

bind multiply_accumulate_datapath mac_checker #(.ADDR_W(ADDR_W)) mac_checker_inst (
	.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .op_valid(op_valid),
	.op_req(op_req), .acc_value(acc_value), .flags(flags));

// ### mac_pkg.sv
// shared constants and carriers for the multiply-accumulate datapath
package mac_pkg;

	// register map, byte addresses
	localparam logic [3:0] ACC_OFFSET    = 4'h0;
	localparam logic [3:0] STATUS_OFFSET = 4'h4;

	// status register fields
	localparam int STAT_OVF_BIT  = 1;
	localparam int STAT_ZERO_BIT = 2;
	localparam int STAT_NEG_BIT  = 3;
	localparam int STAT_RND_BIT  = 4;
	localparam int STAT_FRAC_BIT = 5;
	localparam int STAT_SIGN_BIT = 6;
	localparam int STAT_SAT_BIT  = 7;

	// reset values
	localparam logic [31:0] ACC_RESET  = 32'h0000_0000;
	localparam logic [7:0]  STAT_RESET = 8'h00;

	// saturation and midpoint constants
	localparam logic [31:0] MOST_NEG   = 32'h8000_0000;
	localparam logic [31:0] MOST_POS   = 32'h7FFF_FFFF;
	localparam logic [31:0] ALL_ONES   = 32'hFFFF_FFFF;
	localparam logic [31:0] ALL_ZEROS  = 32'h0000_0000;
	localparam logic [31:0] ROUND_MID  = 32'h8000_0000;
	localparam logic [15:0] HALF_ZERO  = 16'h0000;

	// product shift codes
	localparam logic [1:0] SHIFT_NONE  = 2'h0;
	localparam logic [1:0] SHIFT_LEFT  = 2'h1;
	localparam logic [1:0] SHIFT_RSVD  = 2'h2;
	localparam logic [1:0] SHIFT_RIGHT = 2'h3;

	// one multiply-accumulate request from the core
	typedef struct packed {
		logic        subtract;
		logic        word_size;
		logic        x_half_select;
		logic        y_half_select;
		logic [1:0]  product_shift_code;
		logic [31:0] rx;
		logic [31:0] ry;
	} mac_req_t;

	// flag outputs
	typedef struct packed {
		logic ovf;
		logic neg;
		logic zero;
	} mac_flags_t;

endpackage

// ### multiply_accumulate_datapath.sv
// multiply-accumulate datapath with accumulator and status register
`timescale 1ns/1ps

module multiply_accumulate_datapath
	import mac_pkg::*;
#(
	parameter int ADDR_W = 4
) (
	input  wire logic              core_clk,
	input  wire logic              rst,
	input  wire logic [ADDR_W-1:0] reg_addr,
	input  wire logic [31:0]       reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic [31:0]            reg_rdata,
	input  wire logic              op_valid,
	input  wire mac_req_t          op_req,
	output logic [31:0]            acc_value,
	output mac_flags_t             flags
);

	initial begin
		// the decode reads address bits 3:0 directly, so four bits is the floor
		if (ADDR_W < 4 || ADDR_W > 32) begin
			$error("ADDR_W must lie between 4 and 32");
		end
	end

	logic [31:0] acc_r;
	logic [31:0] acc_nxt;
	logic [7:0]  stat_r;
	logic [7:0]  stat_nxt;
	logic [31:0] rdata_r;
	logic [31:0] rdata_nxt;

	// register decode
	wire logic [3:0] addr_lo    = reg_addr[3:0];
	wire logic       addr_hi_ok = (reg_addr >> 4) == '0;
	wire logic       hit_acc    = addr_hi_ok && addr_lo == ACC_OFFSET;
	wire logic       hit_stat   = addr_hi_ok && addr_lo == STATUS_OFFSET;
	wire logic       wr_acc     = reg_wr && hit_acc;
	wire logic       wr_stat    = reg_wr && hit_stat;

	// status fields
	wire logic sat_en    = stat_r[STAT_SAT_BIT];
	wire logic ovf_now   = stat_r[STAT_OVF_BIT];
	wire logic round_sel = stat_r[STAT_RND_BIT];
	wire logic frac_mode = stat_r[STAT_FRAC_BIT];
	wire logic uns_mode  = stat_r[STAT_SIGN_BIT] && !frac_mode;

	// operations are refused while a register write is in flight,
	// so a direct load never races the datapath
	wire logic op_go   = op_valid && !reg_wr;
	wire logic op_hold = sat_en && ovf_now;
	wire logic op_run  = op_go && !op_hold;

	wire logic is_sub  = op_req.subtract;
	wire logic is_word = op_req.word_size;

	// operand selection
	wire logic [15:0] x_half = op_req.x_half_select ? op_req.rx[31:16] : op_req.rx[15:0];
	wire logic [15:0] y_half = op_req.y_half_select ? op_req.ry[31:16] : op_req.ry[15:0];

	logic [31:0] opnd_x;
	logic [31:0] opnd_y;

	always_comb begin
		if (!is_word) begin
			opnd_x = op_req.rx;
			opnd_y = op_req.ry;
		end else if (frac_mode) begin
			opnd_x = {x_half, HALF_ZERO};
			opnd_y = {y_half, HALF_ZERO};
		end else if (uns_mode) begin
			opnd_x = {HALF_ZERO, x_half};
			opnd_y = {HALF_ZERO, y_half};
		end else begin
			opnd_x = {{16{x_half[15]}}, x_half};
			opnd_y = {{16{y_half[15]}}, y_half};
		end
	end

	// one 33x33 signed multiplier serves both signed and unsigned modes
	wire logic        ext_x = uns_mode ? 1'b0 : opnd_x[31];
	wire logic        ext_y = uns_mode ? 1'b0 : opnd_y[31];
	wire logic [65:0] prod_full = $signed({ext_y, opnd_y}) * $signed({ext_x, opnd_x});
	wire logic [63:0] prod = prod_full[63:0];

	// fractional product path
	wire logic [63:0] frac_prod = {prod[62:0], 1'b0};
	wire logic        rnd_up = (frac_prod[31:0] > ROUND_MID)
		|| (frac_prod[31:0] == ROUND_MID && frac_prod[32]);
	wire logic [31:0] frac_hi = frac_prod[63:32] + {31'b0, round_sel && rnd_up};

	// integer product overflow
	wire logic sgn_povf = !(&prod[63:31]) && (|prod[63:31]);
	wire logic uns_povf = |prod[63:32];
	wire logic povf     = uns_mode ? uns_povf : sgn_povf;

	// left shift overflow
	wire logic lsh_ovf = uns_mode ? prod[31] : (prod[31] ^ prod[30]);

	// right shift msb fill
	wire logic rsh_fill = !uns_mode && prod[31] && !(!is_word && sgn_povf);

	logic [31:0] prod_sh;
	logic        int_povf;

	always_comb begin
		prod_sh  = prod[31:0];
		int_povf = povf;
		case (op_req.product_shift_code)
			SHIFT_LEFT: begin
				if (lsh_ovf) begin
					int_povf = 1'b1;
				end else begin
					prod_sh = {prod[30:0], 1'b0};
				end
			end
			SHIFT_RIGHT: begin
				prod_sh = {rsh_fill, prod[31:1]};
			end
			SHIFT_NONE, SHIFT_RSVD: begin
				prod_sh = prod[31:0];
			end
			default: begin
				prod_sh = prod[31:0];
			end
		endcase
	end

	// value forced by product overflow under saturation
	logic [31:0] prod_sat_val;

	always_comb begin
		if (uns_mode) begin
			prod_sat_val = is_sub ? ALL_ZEROS : ALL_ONES;
		end else if (is_sub) begin
			prod_sat_val = prod[63] ? MOST_POS : MOST_NEG;
		end else begin
			prod_sat_val = prod[63] ? MOST_NEG : MOST_POS;
		end
	end

	// product overflow exists only in integer modes, and the shift is
	// dropped in fractional mode
	wire logic        prod_ovf = !frac_mode && int_povf;
	wire logic        forced   = prod_ovf && sat_en;
	wire logic [31:0] addend   = frac_mode ? frac_hi : prod_sh;

	// accumulate
	wire logic [32:0] sum_wide  = {1'b0, acc_r} + {1'b0, addend};
	wire logic [32:0] diff_wide = {1'b0, acc_r} - {1'b0, addend};
	wire logic [32:0] comb_wide = is_sub ? diff_wide : sum_wide;
	wire logic [31:0] comb_res  = comb_wide[31:0];

	wire logic sgn_aovf = is_sub
		? (acc_r[31] != addend[31]) && (comb_res[31] != acc_r[31])
		: (acc_r[31] == addend[31]) && (comb_res[31] != acc_r[31]);
	wire logic uns_aovf = comb_wide[32];
	wire logic acc_ovf  = !forced && (uns_mode ? uns_aovf : sgn_aovf);

	logic [31:0] acc_sat_val;

	always_comb begin
		if (uns_mode) begin
			acc_sat_val = is_sub ? ALL_ZEROS : ALL_ONES;
		end else begin
			acc_sat_val = comb_res[31] ? MOST_POS : MOST_NEG;
		end
	end

	logic [31:0] result;

	always_comb begin
		if (forced) begin
			result = prod_sat_val;
		end else if (acc_ovf && sat_en) begin
			result = acc_sat_val;
		end else begin
			result = comb_res;
		end
	end

	wire logic res_ovf  = prod_ovf || acc_ovf;
	wire logic res_neg  = result[31];
	wire logic res_zero = result == ALL_ZEROS;

	// next state of the programmer-visible registers
	always_comb begin
		acc_nxt  = acc_r;
		stat_nxt = stat_r;
		if (wr_acc) begin
			acc_nxt               = reg_wdata;
			stat_nxt[STAT_OVF_BIT] = 1'b0;
		end else if (wr_stat) begin
			stat_nxt = reg_wdata[7:0];
		end else if (op_run) begin
			acc_nxt                 = result;
			stat_nxt[STAT_NEG_BIT]  = res_neg;
			stat_nxt[STAT_ZERO_BIT] = res_zero;
			// without saturation the flag stays sticky across operations
			stat_nxt[STAT_OVF_BIT]  = (ovf_now && !sat_en) || res_ovf;
		end
	end

	// read mux; unmapped addresses read zero
	always_comb begin
		rdata_nxt = rdata_r;
		if (reg_rd) begin
			if (hit_acc) begin
				rdata_nxt = acc_r;
			end else if (hit_stat) begin
				rdata_nxt = {24'h000000, stat_r};
			end else begin
				rdata_nxt = ALL_ZEROS;
			end
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			acc_r   <= ACC_RESET;
			stat_r  <= STAT_RESET;
			rdata_r <= ALL_ZEROS;
		end else begin
			acc_r   <= acc_nxt;
			stat_r  <= stat_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	assign reg_rdata  = rdata_r;
	assign acc_value  = acc_r;
	// one driver for the whole carrier; member-wise continuous writes are refused on a variable
	assign flags      = {stat_r[STAT_OVF_BIT], stat_r[STAT_NEG_BIT], stat_r[STAT_ZERO_BIT]};

endmodule

// ### multiply_accumulate_datapath_bench.sv
// self-checking bench for the multiply-accumulate datapath
`timescale 1ns/1ps
module multiply_accumulate_datapath_bench
	import mac_pkg::*;
;
	logic	core_clk, rst, reg_wr, reg_rd, op_valid;
	logic [3:0]	reg_addr;
	logic [31:0]	reg_wdata, reg_rdata, acc_value;
	mac_req_t	op_req;
	mac_flags_t	flags;
	int	bad_count = 0;
	int	comparisons = 0;
	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end
	multiply_accumulate_datapath multiply_accumulate_datapath_inst (.core_clk(core_clk), .rst(rst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .op_valid(op_valid), .op_req(op_req), .acc_value(acc_value), .flags(flags));
	core_model core_model_inst (.core_clk(core_clk), .op_req(op_req), .op_valid(op_valid));
	task finish_test;
		if (bad_count == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task chk(input logic [31:0] g, e);
		comparisons++;
		if (g !== e) begin
			bad_count++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask
	task rd(input logic [3:0] a, input logic [31:0] e);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		@(negedge core_clk);
		chk(reg_rdata, e);
	endtask
	// c = {subtract, word, x upper, y upper, shift code}; f = {ovf, neg, zero}
	task op(input logic [5:0] c, input logic [31:0] x, y, a, input logic [2:0] f);
		core_model_inst.issue({c, x, y});
		@(negedge core_clk);
		chk(acc_value, a);
		chk(32'(flags), 32'(f));
	endtask
	task t_regs;
		wr(4'h0, 32'h1234_5678);
		rd(4'h0, 32'h1234_5678);
		rd(4'hC, 32'h0);
		wr(4'h4, 32'hF2);
		rd(4'h4, 32'hF2);
		wr(4'h0, 32'h1);
		rd(4'h4, 32'hF0);
	endtask
	task t_signed;
		wr(4'h4, 32'h0);
		wr(4'h0, 32'h5);
		op(6'h18, 32'hFFFD_1234, 32'h5678_0004, 32'hFFFF_FFF9, 3'h2);
		op(6'h3B, 32'hFFFD_1234, 32'h5678_0004, 32'hFFFF_FFFF, 3'h2);
		op(6'h01, 32'h3, 32'h1, 32'h5, 3'h0);
		op(6'h02, 32'h3, 32'h1, 32'h8, 3'h0);
		op(6'h20, 32'h8, 32'h1, 32'h0, 3'h1);
	endtask
	task t_unsigned;
		wr(4'h4, 32'hC0);
		wr(4'h0, 32'h0);
		op(6'h00, 32'h1_0000, 32'h1_0000, 32'hFFFF_FFFF, 3'h6);
		op(6'h3B, 32'h5, 32'h5, 32'hFFFF_FFFF, 3'h6);
		wr(4'h0, 32'h5);
		op(6'h20, 32'h1_0000, 32'h1_0000, 32'h0, 3'h5);
		wr(4'h4, 32'h40);
		wr(4'h0, 32'h0);
		op(6'h13, 32'hABCD_FFFF, 32'h2, 32'hFFFF, 3'h0);
	endtask
	task t_frac;
		wr(4'h4, 32'h20);
		wr(4'h0, 32'h0);
		op(6'h15, 32'h4000, 32'h4000_0000, 32'h2000_0000, 3'h0);
		wr(4'h4, 32'h30);
		wr(4'h0, 32'h0);
		op(6'h00, 32'h1, 32'h4000_0001, 32'h1, 3'h0);
		op(6'h00, 32'h1, 32'h4000_0000, 32'h1, 3'h0);
		op(6'h00, 32'h3, 32'h4000_0000, 32'h3, 3'h0);
	endtask
	task t_sat;
		wr(4'h4, 32'h80);
		wr(4'h0, 32'h7FFF_FFFF);
		op(6'h00, 32'h1, 32'h1, 32'h7FFF_FFFF, 3'h4);
		wr(4'h0, 32'h0);
		op(6'h20, 32'h1_0000, 32'h1_0000, 32'h8000_0000, 3'h6);
		wr(4'h4, 32'h02);
		op(6'h00, 32'h1, 32'h1, 32'h8000_0001, 3'h6);
	endtask
	initial begin
		#100000;
		bad_count++;
		finish_test;
	end
	initial begin
		rst = 1'b1;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 4'h0;
		reg_wdata = 32'h0;
		repeat (20) @(posedge core_clk);
		rst <= 1'b0;
		@(negedge core_clk);
		chk(acc_value, 32'h0);
		t_regs;
		t_signed;
		t_unsigned;
		t_frac;
		t_sat;
		finish_test;
	end
endmodule
